// [rtl/msfc_pkg.sv]
// shared constants, states and helper functions of the serial slave frame checker
package msfc_pkg;
  // function codes and framing characters
  localparam logic [7:0] FN_READ = 8'h03;
  localparam logic [7:0] FN_WRITE1 = 8'h06;
  localparam logic [7:0] FN_WRITEN = 8'h10;
  localparam logic [7:0] CH_COLON = 8'h3a;
  localparam logic [7:0] CH_CR = 8'h0d;
  localparam logic [7:0] CH_LF = 8'h0a;
  localparam logic [7:0] BCAST_ADDR = 8'h00;
  // check field constants
  localparam logic [15:0] CRC_PRESET = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'ha001;
  localparam logic [15:0] CRC_RESIDUE = 16'h0000;
  localparam logic [7:0] LRC_RESIDUE = 8'h00;
  // byte offsets inside a received frame
  localparam logic [5:0] OFS_ADDR = 6'h00;
  localparam logic [5:0] OFS_FN = 6'h01;
  localparam logic [5:0] OFS_REG = 6'h02;
  localparam logic [5:0] OFS_CNT = 6'h04;
  localparam logic [5:0] OFS_BCNT = 6'h06;
  localparam logic [5:0] OFS_DATA = 6'h07;
  localparam logic [5:0] OFS_RDATA = 6'h03;
  localparam logic [5:0] SHORT_LEN = 6'h06;
  localparam logic [5:0] LEN_MAX = 6'h3f;
  // sizes
  localparam int MAX_WORDS = 20;
  localparam int BUF_BYTES = 64;
  localparam int FIFO_DEPTH = 16;
  localparam int CHAR_W = 8;
  // timing: idle gap that delimits a binary frame
  localparam int CLK_HZ = 100_000_000;
  localparam int RTU_GAP_MS = 10;
  localparam int RTU_GAP_CYCLES = RTU_GAP_MS * (CLK_HZ / 1000);

  // frame handler states, gray along receive, write, reply
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_RECV = 4'h1,
    ST_CHECK = 4'h3,
    ST_WRITE = 4'h2,
    ST_COLON = 4'h6,
    ST_BODY = 4'h7,
    ST_CHK = 4'h5,
    ST_CR = 4'h4,
    ST_LF = 4'hc
  } msfc_state_t;

  // one byte through the crc: xor into low byte, then eight shift steps
  function automatic logic [15:0] crc_step(input logic [15:0] crc, input logic [7:0] b);
    logic [15:0] c;
    c = crc ^ {8'h00, b};
    for (int j = 0; j < 8; j++)
    begin
      c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction : crc_step

  // nibble to ascii hex character
  function automatic logic [7:0] hex_char(input logic [3:0] n);
    return (n < 4'ha) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
  endfunction : hex_char

  // ascii hex character to {valid, nibble}
  function automatic logic [4:0] hex_val(input logic [7:0] c);
    logic [4:0] r;
    r = 5'h00;
    if (c >= 8'h30 && c <= 8'h39)
    begin
      r = {1'b1, c[3:0]};
    end
    else if ((c >= 8'h41 && c <= 8'h46) || (c >= 8'h61 && c <= 8'h66))
    begin
      r = {1'b1, c[3:0] + 4'h9};
    end
    return r;
  endfunction : hex_val
endpackage : msfc_pkg

// [rtl/msfc_stream_if.sv]
// valid/ready character stream between the frame handler and its fifo
`timescale 1ns/10ps
interface msfc_stream_if #(parameter int W = 8) ();
  logic [W-1:0] data;
  logic valid;
  logic ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface : msfc_stream_if

// [rtl/msfc_fifo.sv]
// synchronous fifo with valid/ready on both sides
`timescale 1ns/10ps
module msfc_fifo
  import msfc_pkg::*;
#(
  parameter int W = CHAR_W,
  parameter int DEPTH = FIFO_DEPTH
)
(
  input wire logic sys_clk,
  input wire logic rst,
  msfc_stream_if.snk push_if,
  msfc_stream_if.src pop_if
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem_q [DEPTH];
  logic [W-1:0] mem_d [DEPTH];
  logic [AW-1:0] wptr_q, wptr_d, rptr_q, rptr_d;
  logic [AW:0] cnt_q, cnt_d;
  logic do_push, do_pop;

  // handshakes and honest flags
  assign push_if.ready = (cnt_q != (AW+1)'(DEPTH));
  assign pop_if.valid = (cnt_q != '0);
  assign pop_if.data = mem_q[rptr_q];
  assign do_push = push_if.valid && push_if.ready;
  assign do_pop = pop_if.valid && pop_if.ready;

  // pointer and storage next values
  always_comb
  begin
    mem_d = mem_q;
    wptr_d = wptr_q;
    rptr_d = rptr_q;
    cnt_d = cnt_q;
    if (do_push)
    begin
      mem_d[wptr_q] = push_if.data;
      wptr_d = (wptr_q == AW'(DEPTH - 1)) ? '0 : wptr_q + 1'b1;
    end
    if (do_pop)
    begin
      rptr_d = (rptr_q == AW'(DEPTH - 1)) ? '0 : rptr_q + 1'b1;
    end
    cnt_d = cnt_q + (AW+1)'(do_push) - (AW+1)'(do_pop);
  end

  // registers
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      wptr_q <= '0;
      rptr_q <= '0;
      cnt_q <= '0;
      for (int i = 0; i < DEPTH; i++)
      begin
        mem_q[i] <= '0;
      end
    end
    else
    begin
      wptr_q <= wptr_d;
      rptr_q <= rptr_d;
      cnt_q <= cnt_d;
      mem_q <= mem_d;
    end
  end
endmodule : msfc_fifo

// [rtl/msfc_top.sv]
// serial slave frame checker: parses, checks, executes and answers register frames
//
// Contract
// - read request answered with address, function, byte count twice words, words high first, check.
// - function 06 writes one 16-bit value to one register, both high byte first.
// - single write answered with an exact echo of the command.
// - function 10 carries start, word count, byte count, data; words stored consecutively.
// - at most 20 data words in one multi-register write.
// - ascii check sums every byte from address to last data byte modulo 256.
// - sent ascii check is the two's complement of that sum, in hex.
// - binary crc accumulator preset to all ones before the first byte.
// - each byte is xored into the accumulator low byte before shifting.
// - shift right with zero fill; xor a001 when a one drops out.
// - exactly eight shift steps per byte.
// - repeat for every byte; final accumulator is the crc.
// - crc sent low byte first, then high byte.
// - ascii fields carried as two hex characters, high nibble first.
// - ascii frame starts with colon, ends with carriage return then line feed.
// - binary frame delimited by an idle line longer than 10 ms.
// - address 00 is a broadcast that every unit accepts; here a read (function 03) sent to 00 is dropped unanswered.
`timescale 1ns/10ps
module msfc_top
  import msfc_pkg::*;
#(
  parameter int GAP_CYCLES = RTU_GAP_CYCLES,
  parameter int MAX_W = MAX_WORDS,
  parameter int TX_DEPTH = FIFO_DEPTH
)
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic rx_valid,
  input wire logic [7:0] rx_char,
  input wire logic ascii_mode,
  input wire logic [7:0] unit_addr,
  output logic [7:0] tx_char,
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [15:0] reg_rd_addr,
  input wire logic [15:0] reg_rd_data,
  output logic reg_wr_en,
  output logic [15:0] reg_wr_addr,
  output logic [15:0] reg_wr_data
);
  localparam int GW = $clog2(GAP_CYCLES + 1);

  msfc_state_t state_q, state_d;
  logic [7:0] buf_q [BUF_BYTES];
  logic [7:0] buf_d [BUF_BYTES];
  logic [5:0] len_q, len_d, idx_q, idx_d;
  logic [4:0] wi_q, wi_d;
  logic [3:0] hi_q, hi_d;
  logic nib_q, nib_d, cr_q, cr_d;
  logic [7:0] lrc_q, lrc_d;
  logic [15:0] crc_q, crc_d;
  logic [GW-1:0] idle_q, idle_d;
  logic wr_en_q, wr_en_d;
  logic [15:0] wr_addr_q, wr_addr_d, wr_data_q, wr_data_d;
  logic ascii_m_q, ascii_q;
  logic [7:0] addr_m_q, addr_q;
  logic gap_ok, chk_ok, bcast, wc_ok, frame_ok, wlast, push_ok;
  logic [4:0] hv;
  logic [7:0] f_addr, f_fn, f_bcnt, body, chk_byte;
  logic [15:0] f_reg, f_cnt;
  logic [5:0] plen, body_last, rw;
  logic [7:0] push_char;
  logic push;

  msfc_stream_if #(.W(CHAR_W)) tx_in ();
  msfc_stream_if #(.W(CHAR_W)) tx_out ();

  // reply characters wait here until the line transmitter takes them
  msfc_fifo #(.W(CHAR_W), .DEPTH(TX_DEPTH)) u_tx_fifo (
    .sys_clk(sys_clk),
    .rst(rst),
    .push_if(tx_in),
    .pop_if(tx_out)
  );

  assign tx_in.data = push_char;
  assign tx_in.valid = push;
  assign push_ok = tx_in.ready;
  assign tx_char = tx_out.data;
  assign tx_valid = tx_out.valid;
  assign tx_out.ready = tx_ready;
  assign reg_wr_en = wr_en_q;
  assign reg_wr_addr = wr_addr_q;
  assign reg_wr_data = wr_data_q;

  // fields of the frame held in the buffer
  assign f_addr = buf_q[OFS_ADDR];
  assign f_fn = buf_q[OFS_FN];
  assign f_reg = {buf_q[OFS_REG], buf_q[OFS_REG + 6'h01]};
  assign f_cnt = {buf_q[OFS_CNT], buf_q[OFS_CNT + 6'h01]};
  assign f_bcnt = buf_q[OFS_BCNT];
  assign hv = hex_val(rx_char);

  // frame acceptance
  assign gap_ok = (idle_q == GW'(GAP_CYCLES));
  assign chk_ok = ascii_q ? (lrc_q == LRC_RESIDUE) : (crc_q == CRC_RESIDUE);
  assign plen = len_q - (ascii_q ? 6'h01 : 6'h02);
  assign bcast = (f_addr == BCAST_ADDR);
  assign wc_ok = (f_cnt != 16'h0000) && (f_cnt <= 16'(MAX_W));
  always_comb
  begin
    frame_ok = 1'b0;
    if (chk_ok && (bcast || f_addr == addr_q))
    begin
      case (f_fn)
        FN_READ: frame_ok = (plen == SHORT_LEN) && wc_ok && !bcast;
        FN_WRITE1: frame_ok = (plen == SHORT_LEN);
        FN_WRITEN: frame_ok = wc_ok && (f_bcnt == {f_cnt[6:0], 1'b0})
                              && ({2'b00, plen} == OFS_DATA + f_bcnt);
        default: frame_ok = 1'b0;
      endcase
    end
  end

  // reply byte for the current body index
  assign rw = (idx_q - OFS_RDATA) >> 1;
  assign reg_rd_addr = f_reg + {11'h000, rw[4:0]};
  assign chk_byte = ascii_q ? (8'h00 - lrc_q) : (nib_q ? crc_q[15:8] : crc_q[7:0]);
  always_comb
  begin
    body = buf_q[idx_q];
    body_last = OFS_CNT + 6'h01;
    if (f_fn == FN_READ)
    begin
      body_last = 6'({f_cnt[4:0], 1'b0}) + 6'h02;
      if (idx_q == OFS_REG)
      begin
        body = {f_cnt[6:0], 1'b0};
      end
      else if (idx_q >= OFS_RDATA)
      begin
        body = idx_q[0] ? reg_rd_data[15:8] : reg_rd_data[7:0];
      end
    end
  end

  // last word of the write phase
  assign wlast = (f_fn == FN_WRITE1) || ({11'h000, wi_q} + 16'h0001 == f_cnt);

  // line idle counter, saturating at the gap length
  assign idle_d = rx_valid ? '0 : (gap_ok ? idle_q : idle_q + 1'b1);

  // frame handler next state
  always_comb
  begin
    state_d = state_q;
    buf_d = buf_q;
    len_d = len_q;
    idx_d = idx_q;
    wi_d = wi_q;
    hi_d = hi_q;
    nib_d = nib_q;
    cr_d = cr_q;
    lrc_d = lrc_q;
    crc_d = crc_q;
    wr_en_d = 1'b0;
    wr_addr_d = wr_addr_q;
    wr_data_d = wr_data_q;
    push = 1'b0;
    push_char = 8'h00;
    case (state_q)
      ST_IDLE:
      begin
        if (rx_valid && ascii_q && rx_char == CH_COLON)
        begin
          state_d = ST_RECV;
          len_d = '0;
          nib_d = 1'b0;
          cr_d = 1'b0;
          lrc_d = 8'h00;
        end
        else if (rx_valid && !ascii_q && gap_ok)
        begin
          state_d = ST_RECV;
          buf_d[0] = rx_char;
          len_d = 6'h01;
          crc_d = crc_step(CRC_PRESET, rx_char);
        end
      end
      ST_RECV:
      begin
        if (ascii_q && rx_valid)
        begin
          if (rx_char == CH_COLON)
          begin
            len_d = '0;
            nib_d = 1'b0;
            cr_d = 1'b0;
            lrc_d = 8'h00;
          end
          else if (cr_q)
          begin
            state_d = (rx_char == CH_LF) ? ST_CHECK : ST_IDLE;
          end
          else if (rx_char == CH_CR)
          begin
            cr_d = 1'b1;
            state_d = nib_q ? ST_IDLE : ST_RECV;
          end
          else if (!hv[4] || len_q == LEN_MAX)
          begin
            state_d = ST_IDLE;
          end
          else if (!nib_q)
          begin
            hi_d = hv[3:0];
            nib_d = 1'b1;
          end
          else
          begin
            buf_d[len_q] = {hi_q, hv[3:0]};
            len_d = len_q + 6'h01;
            lrc_d = lrc_q + {hi_q, hv[3:0]};
            nib_d = 1'b0;
          end
        end
        else if (!ascii_q && rx_valid)
        begin
          if (len_q == LEN_MAX)
          begin
            state_d = ST_IDLE;
          end
          else
          begin
            buf_d[len_q] = rx_char;
            len_d = len_q + 6'h01;
            crc_d = crc_step(crc_q, rx_char);
          end
        end
        else if (!ascii_q && gap_ok)
        begin
          state_d = ST_CHECK;
        end
      end
      ST_CHECK:
      begin
        idx_d = '0;
        wi_d = '0;
        nib_d = 1'b0;
        lrc_d = 8'h00;
        crc_d = CRC_PRESET;
        if (!frame_ok)
        begin
          state_d = ST_IDLE;
        end
        else if (f_fn == FN_READ)
        begin
          state_d = ascii_q ? ST_COLON : ST_BODY;
        end
        else
        begin
          state_d = ST_WRITE;
        end
      end
      ST_WRITE:
      begin
        wr_en_d = 1'b1;
        wr_addr_d = f_reg + {11'h000, wi_q};
        if (f_fn == FN_WRITE1)
        begin
          wr_data_d = {buf_q[OFS_CNT], buf_q[OFS_CNT + 6'h01]};
        end
        else
        begin
          wr_data_d = {buf_q[OFS_DATA + {wi_q, 1'b0}], buf_q[OFS_DATA + {wi_q, 1'b0} + 6'h01]};
        end
        wi_d = wi_q + 5'h01;
        if (wlast)
        begin
          state_d = bcast ? ST_IDLE : (ascii_q ? ST_COLON : ST_BODY);
        end
      end
      ST_COLON:
      begin
        push = 1'b1;
        push_char = CH_COLON;
        if (push_ok)
        begin
          state_d = ST_BODY;
        end
      end
      ST_BODY:
      begin
        push = 1'b1;
        push_char = ascii_q ? hex_char(nib_q ? body[3:0] : body[7:4]) : body;
        if (push_ok && ascii_q && !nib_q)
        begin
          nib_d = 1'b1;
        end
        else if (push_ok)
        begin
          nib_d = 1'b0;
          lrc_d = lrc_q + body;
          crc_d = crc_step(crc_q, body);
          idx_d = idx_q + 6'h01;
          state_d = (idx_q == body_last) ? ST_CHK : ST_BODY;
        end
      end
      ST_CHK:
      begin
        push = 1'b1;
        push_char = ascii_q ? hex_char(nib_q ? chk_byte[3:0] : chk_byte[7:4]) : chk_byte;
        if (push_ok)
        begin
          nib_d = !nib_q;
          if (nib_q)
          begin
            state_d = ascii_q ? ST_CR : ST_IDLE;
          end
        end
      end
      ST_CR:
      begin
        push = 1'b1;
        push_char = CH_CR;
        state_d = push_ok ? ST_LF : ST_CR;
      end
      ST_LF:
      begin
        push = 1'b1;
        push_char = CH_LF;
        state_d = push_ok ? ST_IDLE : ST_LF;
      end
      default: state_d = ST_IDLE;
    endcase
  end

  // registers of the frame handler and the pin synchronisers
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      state_q <= ST_IDLE;
      len_q <= '0;
      idx_q <= '0;
      wi_q <= '0;
      hi_q <= '0;
      nib_q <= 1'b0;
      cr_q <= 1'b0;
      lrc_q <= 8'h00;
      crc_q <= CRC_PRESET;
      idle_q <= '0;
      wr_en_q <= 1'b0;
      wr_addr_q <= 16'h0000;
      wr_data_q <= 16'h0000;
      ascii_m_q <= 1'b0;
      ascii_q <= 1'b0;
      addr_m_q <= 8'h00;
      addr_q <= 8'h00;
      for (int i = 0; i < BUF_BYTES; i++)
      begin
        buf_q[i] <= 8'h00;
      end
    end
    else
    begin
      state_q <= state_d;
      len_q <= len_d;
      idx_q <= idx_d;
      wi_q <= wi_d;
      hi_q <= hi_d;
      nib_q <= nib_d;
      cr_q <= cr_d;
      lrc_q <= lrc_d;
      crc_q <= crc_d;
      idle_q <= idle_d;
      wr_en_q <= wr_en_d;
      wr_addr_q <= wr_addr_d;
      wr_data_q <= wr_data_d;
      ascii_m_q <= ascii_mode;
      ascii_q <= ascii_m_q;
      addr_m_q <= unit_addr;
      addr_q <= addr_m_q;
      buf_q <= buf_d;
    end
  end

  // checks on the frame handler
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_tx_cr;
    (state_q == ST_CR) && push_ok;
  endsequence
  sequence s_tx_lf;
    (state_q == ST_LF) && push && (push_char == CH_LF);
  endsequence

  a_crc_first_byte: assert property (state_q == ST_IDLE && rx_valid && !ascii_q && gap_ok
    |=> crc_q == crc_step(16'hffff, $past(rx_char)))
    else $error("crc not preset before first byte");
  a_crc_bitwise: assert property (state_q == ST_RECV && rx_valid && !ascii_q && len_q != LEN_MAX
    |=> crc_q == crc_step($past(crc_q), $past(rx_char)))
    else $error("crc byte step wrong");
  a_lrc_negated: assert property (state_q == ST_CHK && ascii_q && !nib_q && push
    |-> push_char == hex_char(4'((8'h00 - lrc_q) >> 4)))
    else $error("lrc not negated sum");
  a_crc_low_first: assert property (state_q == ST_CHK && !ascii_q && push_ok && !nib_q
    |-> push_char == crc_q[7:0] ##1 (push_char == crc_q[15:8]))
    else $error("crc byte order wrong");
  a_end_crlf: assert property (s_tx_cr |=> s_tx_lf)
    else $error("carriage return not followed by line feed");
  a_bad_drop: assert property (state_q == ST_CHECK && !chk_ok
    |=> state_q == ST_IDLE ##1 (state_q == ST_IDLE || state_q == ST_RECV))
    else $error("bad frame not dropped");
  a_read_count: assert property (state_q == ST_BODY && !ascii_q && f_fn == FN_READ && idx_q == 6'h02
    |-> push_char == {f_cnt[6:0], 1'b0})
    else $error("read byte count wrong");
  a_wr_consec: assert property (wr_en_q && $past(wr_en_q) && f_fn == FN_WRITEN
    |-> wr_addr_q == $past(wr_addr_q) + 16'h0001)
    else $error("multi write not consecutive");
  a_word_limit: assert property (state_q == ST_WRITE |-> wi_q < 5'(MAX_W))
    else $error("too many words written");
  a_single_write: assert property (state_q == ST_WRITE && f_fn == FN_WRITE1
    |=> wr_en_q && wr_addr_q == f_reg && state_q != ST_WRITE)
    else $error("single write wrong");
  a_bcast_silent: assert property (state_q == ST_WRITE && wlast && bcast |=> state_q == ST_IDLE)
    else $error("broadcast answered");
  a_mw_short_reply: assert property (state_q == ST_BODY && f_fn != FN_READ |-> idx_q <= 6'h05)
    else $error("multi write reply too long");
endmodule : msfc_top

// [testbench/msfc_host_model.sv]
// host side model: sends characters, takes reply characters, may stall
`timescale 1ns/10ps
module msfc_host_model
(
  input wire logic sys_clk,
  input wire logic rst,
  output logic rx_valid,
  output logic [7:0] rx_char,
  input wire logic [7:0] tx_char,
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic stall
);
  logic [7:0] got_q[$];
  logic [1:0] ph_q;
  initial
  begin
    rx_valid = 1'b0;
    rx_char = 8'h00;
    tx_ready = 1'b0;
    ph_q = 2'h0;
  end
  // take reply characters; when stalling, ready one cycle in four
  always @(posedge sys_clk)
  begin
    if (tx_valid === 1'b1 && tx_ready === 1'b1)
      got_q.push_back(tx_char);
    ph_q <= ph_q + 2'h1;
    tx_ready <= !rst && (!stall || ph_q == 2'h3);
  end
  // one character as a single-cycle strobe; line data scrambled after
  task automatic send_char(input logic [7:0] c);
    @(posedge sys_clk);
    rx_valid <= 1'b1;
    rx_char <= c;
    @(posedge sys_clk);
    rx_valid <= 1'b0;
    rx_char <= ~c;
  endtask : send_char
endmodule : msfc_host_model

// [testbench/tb_top.sv]
// self-checking bench of the serial slave frame checker
`timescale 1ns/10ps
module tb_top;
  import msfc_pkg::*;
  typedef logic [7:0] msfc_tb_bq_t[$];
  localparam int GAP = 50;
  localparam logic [15:0] RD_MASK = 16'ha5c3;
  logic sys_clk, rst, rx_valid, ascii_mode, tx_valid, tx_ready, reg_wr_en, stall;
  logic [7:0] rx_char, unit_addr, tx_char;
  logic [15:0] reg_rd_addr, reg_rd_data, reg_wr_addr, reg_wr_data;
  logic [31:0] wr_q[$];
  int n_mismatch, n_tests, cyc;
  msfc_top #(.GAP_CYCLES(GAP)) msfc_top_inst (.sys_clk(sys_clk), .rst(rst), .rx_valid(rx_valid),
    .rx_char(rx_char), .ascii_mode(ascii_mode), .unit_addr(unit_addr), .tx_char(tx_char),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .reg_rd_addr(reg_rd_addr), .reg_rd_data(reg_rd_data),
    .reg_wr_en(reg_wr_en), .reg_wr_addr(reg_wr_addr), .reg_wr_data(reg_wr_data));
  msfc_host_model msfc_host_model_inst (.sys_clk(sys_clk), .rst(rst), .rx_valid(rx_valid),
    .rx_char(rx_char), .tx_char(tx_char), .tx_valid(tx_valid), .tx_ready(tx_ready), .stall(stall));
  // register file stand-in: content derived from address
  assign reg_rd_data = reg_rd_addr ^ RD_MASK;
  // clock, write monitor and hang guard
  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
  begin
    if (reg_wr_en === 1'b1 && !rst)
      wr_q.push_back({reg_wr_addr, reg_wr_data});
    cyc++;
    if (cyc == 80000)
    begin
      n_mismatch++;
      conclude();
    end
  end
  task automatic conclude();
    $display("tests=%0d mismatches=%0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : conclude
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  function automatic logic [7:0] hx(input logic [3:0] n);
    return (n < 4'ha) ? 8'h30 + {4'h0, n} : 8'h37 + {4'h0, n};
  endfunction : hx
  // bench's own crc of a byte list
  function automatic logic [15:0] crc16(msfc_tb_bq_t b);
    logic [15:0] c;
    c = CRC_PRESET;
    foreach (b[i])
    begin
      c = c ^ {8'h00, b[i]};
      repeat (8)
        c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction : crc16
  // wrap a byte list as a line frame in the current mode
  function automatic msfc_tb_bq_t enc(msfc_tb_bq_t b);
    msfc_tb_bq_t o;
    logic [7:0] s;
    logic [15:0] c;
    s = 8'h00;
    c = crc16(b);
    if (ascii_mode)
    begin
      o.push_back(CH_COLON);
      foreach (b[i])
        s = s + b[i];
      b.push_back(8'h00 - s);
      foreach (b[i])
      begin
        o.push_back(hx(b[i][7:4]));
        o.push_back(hx(b[i][3:0]));
      end
      o.push_back(CH_CR);
      o.push_back(CH_LF);
    end
    else
    begin
      o = b;
      o.push_back(c[7:0]);
      o.push_back(c[15:8]);
    end
    return o;
  endfunction : enc
  task automatic mode(input logic m);
    @(posedge sys_clk);
    ascii_mode <= m;
    repeat (4) @(posedge sys_clk);
  endtask : mode
  // send one request, optionally with a spoilt check, and compare the reply
  task automatic xfer(input msfc_tb_bq_t q, input msfc_tb_bq_t r, input logic bad);
    msfc_tb_bq_t o, e, g;
    int k;
    o = enc(q);
    if (r.size() > 0)
      e = enc(r);
    k = o.size() - (ascii_mode ? 3 : 1);
    if (bad)
      o[k] = (o[k] == 8'h30) ? 8'h31 : 8'h30;
    msfc_host_model_inst.got_q.delete();
    wr_q.delete();
    if (!ascii_mode)
      repeat (GAP + 5) @(posedge sys_clk);
    foreach (o[i])
      msfc_host_model_inst.send_char(o[i]);
    if (!ascii_mode)
      repeat (GAP + 5) @(posedge sys_clk);
    for (k = 0; k < ((e.size() > 0) ? 3000 : 300) && msfc_host_model_inst.got_q.size() < e.size(); k++)
      @(posedge sys_clk);
    repeat (30) @(posedge sys_clk);
    g = msfc_host_model_inst.got_q;
    chk(32'(g.size()), 32'(e.size()));
    foreach (e[i])
      if (i < g.size())
        chk({24'h0, g[i]}, {24'h0, e[i]});
  endtask : xfer
  // single write with echo, or dropped when the check is spoilt
  task automatic s_single(input logic bad);
    msfc_tb_bq_t q, r;
    mode(1'b1);
    q = '{8'h01, FN_WRITE1, 8'h01, 8'h00, 8'h17, 8'h70};
    if (!bad)
      r = q;
    xfer(q, r, bad);
    chk(32'(wr_q.size()), bad ? 32'h0 : 32'h1);
    if (!bad && wr_q.size() > 0)
      chk(wr_q[0], 32'h01001770);
  endtask : s_single
  // register read of n words from 2102
  task automatic s_read(input logic m, input logic [7:0] adr, input logic [7:0] n, input logic slow);
    msfc_tb_bq_t q, r;
    logic [15:0] d;
    mode(m);
    stall <= slow;
    q = '{adr, FN_READ, 8'h21, 8'h02, 8'h00, n};
    r = '{adr, FN_READ, 8'(2 * n)};
    for (int i = 0; i < n; i++)
    begin
      d = (16'h2102 + 16'(i)) ^ RD_MASK;
      r.push_back(d[15:8]);
      r.push_back(d[7:0]);
    end
    if (adr == BCAST_ADDR)
      r.delete();
    xfer(q, r, 1'b0);
    stall <= 1'b0;
  endtask : s_read
  // multi write of n words at 0500 in binary mode
  task automatic s_multi(input logic [7:0] n, input logic slow, input logic bad);
    msfc_tb_bq_t q, r;
    logic [15:0] d;
    int ok;
    mode(1'b0);
    stall <= slow;
    ok = (n <= MAX_WORDS) && !bad;
    q = '{8'h01, FN_WRITEN, 8'h05, 8'h00, 8'h00, n, 8'(2 * n)};
    for (int i = 0; i < n; i++)
    begin
      d = 16'h1388 + 16'(i) * 16'h0101;
      q.push_back(d[15:8]);
      q.push_back(d[7:0]);
    end
    if (ok)
      r = '{8'h01, FN_WRITEN, 8'h05, 8'h00, 8'h00, n};
    xfer(q, r, bad);
    chk(32'(wr_q.size()), ok ? 32'(n) : 32'h0);
    foreach (wr_q[i])
      chk(wr_q[i], {16'h0500 + 16'(i), 16'h1388 + 16'(i) * 16'h0101});
    stall <= 1'b0;
  endtask : s_multi
  // broadcast write executed silently; other unit's frame ignored
  task automatic s_bcast();
    msfc_tb_bq_t q, r;
    mode(1'b0);
    q = '{BCAST_ADDR, FN_WRITE1, 8'h00, 8'h2a, 8'hbe, 8'hef};
    xfer(q, r, 1'b0);
    chk(32'(wr_q.size()), 32'h1);
    chk(wr_q[0], 32'h002abeef);
    q[0] = 8'h02;
    xfer(q, r, 1'b0);
    chk(32'(wr_q.size()), 32'h0);
  endtask : s_bcast
  // reset, then the scenarios in turn
  initial
  begin
    sys_clk = 1'b0;
    rst = 1'b1;
    ascii_mode = 1'b1;
    unit_addr = 8'h01;
    stall = 1'b0;
    n_mismatch = 0;
    n_tests = 0;
    cyc = 0;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    s_single(1'b0);
    s_single(1'b1);
    s_read(1'b0, 8'h01, 8'h02, 1'b0);
    s_read(1'b1, 8'h01, 8'h02, 1'b0);
    s_read(1'b1, 8'h01, 8'h14, 1'b1);
    s_read(1'b0, 8'h00, 8'h01, 1'b0);
    s_multi(8'h02, 1'b0, 1'b0);
    s_multi(8'h14, 1'b1, 1'b0);
    s_multi(8'h15, 1'b0, 1'b0);
    s_multi(8'h02, 1'b0, 1'b1);
    s_bcast();
    conclude();
  end
endmodule : tb_top
